// >>> tb_tct_timer01.sv
/*
  Self-checking bench for tct_timer01 with a reference model.
  Assumes tct_wb_host as bus master and the bound checker.
*/
`timescale 1ns/100ps
module tb_tct_timer01
  import tct_pkg::*;
;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [1:0] pin = 2'h3;
  logic [1:0] gat = 2'h0;
  logic ext = 1'b0;
  tct_wb_req_s wb;
  logic ack, irq0, irq1, tick;
  logic [31:0] dat;
  int error_cnt = 0;
  int n_tests = 0;
  int ec = 0;
  int dv[5] = '{12, 4, 48, 80, 1};

  initial forever #5 i_mclk = ~i_mclk;
  // external clock with a period of ten system cycles
  always @(posedge i_mclk) begin
    ec <= (ec == 4) ? 0 : ec + 1;
    if (ec == 4) ext <= ~ext;
  end

  tct_timer01 uut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_wb(wb), .o_wb_ack(ack),
    .o_wb_dat(dat), .i_count0_pin(pin[0]), .i_count1_pin(pin[1]), .i_gating0(gat[0]),
    .i_gating1(gat[1]), .i_ext_clk(ext), .o_irq0(irq0), .o_irq1(irq1), .o_ovf1_tick(tick));
  tct_wb_host u_host (.i_mclk(i_mclk), .i_ack(ack), .i_dat(dat), .o_wb(wb));

  // ==========================================================================
  // helpers
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] q;
    u_host.xfer(1'b0, a, 8'h0, q);
    chk(q & m, e & m);
  endtask
  // three cycles per level keeps events under a quarter of the clock
  task automatic pulse(input int t, input int n);
    repeat (n) begin
      @(posedge i_mclk);
      pin[t] <= 1'b0;
      repeat (3) @(posedge i_mclk);
      pin[t] <= 1'b1;
      repeat (2) @(posedge i_mclk);
    end
    repeat (5) @(posedge i_mclk);
  endtask
  // first interval may be partial after a change, so measure the third
  task automatic per(input int e);
    int n;
    repeat (3) begin
      n = 0;
      do begin
        @(posedge i_mclk);
        n++;
      end while (tick !== 1'b1 && n < 300);
    end
    chk(16'(n), 16'(e));
  endtask
  function automatic int mdl(input int m, input int h, input int l, input int n);
    int f, c;
    f = 0;
    repeat (n) begin
      case (m)
        0: begin
          c = ((h << 5) | (l & 31)) + 1;
          f |= c >> 13;
          h = (c >> 5) & 255;
          l = (l & 224) | (c & 31);
        end
        1: begin
          c = h * 256 + l + 1;
          f |= c >> 16;
          h = (c >> 8) & 255;
          l = c & 255;
        end
        default: begin
          l++;
          if (l > 255) begin
            f = 1;
            l = h;
          end
        end
      endcase
    end
    return (f << 16) | (h << 8) | l;
  endfunction
  task automatic summarize();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // tests
  initial begin
    #200000;
    error_cnt++;
    summarize();
  end
  initial begin
    int m, t, h, l, n, r, o;
    void'($urandom(9047));
    repeat (10) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    for (o = 0; o <= 32; o += 4) rc(8'(o), 8'hff, 8'h0);
    wr(8'h30, 8'hff);
    rc(8'h30, 8'hff, 8'h0);
    wr(TCT_OFS_IEN, 8'h03);
    for (m = 0; m < 3; m++) begin
      for (t = 0; t < 2; t++) begin
        h = (m == 2) ? $urandom % 256 : 255;
        l = 250 + $urandom % 6;
        n = 1 + $urandom % 6;
        o = t * 8;
        wr(TCT_OFS_MODE, 8'((m + 4) << (4 * t)));
        wr(TCT_OFS_C0L + 8'(o), 8'(l));
        wr(TCT_OFS_C0H + 8'(o), 8'(h));
        wr(TCT_OFS_CTRL, 8'(16 << (2 * t)));
        pulse(t, n);
        r = mdl(m, h, l, n);
        rc(TCT_OFS_CTRL, 8'hff, 8'((16 + 32 * (r >> 16)) << (2 * t)));
        chk({14'h0, irq1, irq0}, 16'((r >> 16) << t));
        wr(TCT_OFS_CTRL, 8'h0);
        rc(TCT_OFS_C0L + 8'(o), (m == 0) ? 8'h1f : 8'hff, 8'(r));
        rc(TCT_OFS_C0H + 8'(o), 8'hff, 8'(r >> 8));
      end
    end
    for (t = 0; t < 2; t++) begin
      wr(TCT_OFS_EXT, 8'(3 * t));
      gat <= t ? 2'h0 : 2'h3;
      wr(TCT_OFS_MODE, 8'h0d);
      wr(TCT_OFS_C0L, 8'h0);
      wr(TCT_OFS_CTRL, 8'h10);
      pulse(0, 2);
      gat <= t ? 2'h3 : 2'h0;
      pulse(0, 3);
      rc(TCT_OFS_C0L, 8'hff, 8'h3);
    end
    wr(TCT_OFS_MODE, 8'h20);
    wr(TCT_OFS_C1L, 8'hff);
    wr(TCT_OFS_C1H, 8'hff);
    wr(TCT_OFS_CTRL, 8'h40);
    foreach (dv[i]) begin
      wr(TCT_OFS_CLK, 8'(i < 4 ? i : 8));
      per(dv[i]);
    end
    wr(TCT_OFS_CLK, 8'h05);
    // drop run1 first: in split mode it would clock the high half
    wr(TCT_OFS_CTRL, 8'h00);
    wr(TCT_OFS_MODE, 8'h27);
    wr(TCT_OFS_CTRL, 8'h10);
    per(4);
    rc(TCT_OFS_CTRL, 8'hff, 8'h10);
    wr(TCT_OFS_C0L, 8'hfe);
    wr(TCT_OFS_C0H, 8'h10);
    pulse(0, 3);
    rc(TCT_OFS_C0L, 8'hff, 8'h01);
    rc(TCT_OFS_C0H, 8'hff, 8'h10);
    rc(TCT_OFS_CTRL, 8'hff, 8'h30);
    wr(TCT_OFS_MODE, 8'h37);
    per(300);
    wr(TCT_OFS_C0H, 8'hff);
    wr(TCT_OFS_CTRL, 8'h40);
    rc(TCT_OFS_CTRL, 8'hff, 8'hc0);
    chk({15'h0, irq1}, 16'h1);
    summarize();
  end
endmodule

// >>> tct_pkg.sv
/*
  Package for the dual counter/timer block: register offsets, field
  positions, reset values, prescaler divisors and the bus carrier struct.
  Assumes a single 100 MHz system clock and a classic Wishbone master.
*/
package tct_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] TCT_OFS_CTRL = 8'h00;   // timer_control_status_reg
  localparam logic [7:0] TCT_OFS_MODE = 8'h04;   // timer_mode_reg
  localparam logic [7:0] TCT_OFS_CLK = 8'h08;    // clock_control_reg
  localparam logic [7:0] TCT_OFS_EXT = 8'h0c;    // ext_irq_config_reg
  localparam logic [7:0] TCT_OFS_C0L = 8'h10;    // first_count_low_byte
  localparam logic [7:0] TCT_OFS_C0H = 8'h14;    // first_count_high_byte
  localparam logic [7:0] TCT_OFS_C1L = 8'h18;    // second_count_low_byte
  localparam logic [7:0] TCT_OFS_C1H = 8'h1c;    // second_count_high_byte
  localparam logic [7:0] TCT_OFS_IEN = 8'h20;    // irq enable bits

  // ==========================================================================
  // field positions
  localparam int TCT_B_RUN0 = 4;
  localparam int TCT_B_OVF0 = 5;
  localparam int TCT_B_RUN1 = 6;
  localparam int TCT_B_OVF1 = 7;
  localparam int TCT_B_MODE0 = 0;   // two bits
  localparam int TCT_B_CSEL0 = 2;
  localparam int TCT_B_FIRST_GATE_BIT = 3;
  localparam int TCT_B_MODE1 = 4;   // two bits
  localparam int TCT_B_CSEL1 = 6;
  localparam int TCT_B_GATE1 = 7;
  localparam int TCT_B_PSC = 0;     // two bits
  localparam int TCT_B_CKS0 = 2;
  localparam int TCT_B_CKS1 = 3;
  localparam int TCT_B_POL0 = 0;
  localparam int TCT_B_POL1 = 1;
  localparam int TCT_B_IEN0 = 0;
  localparam int TCT_B_IEN1 = 1;

  // ==========================================================================
  // reset values
  localparam logic [7:0] TCT_RST_BYTE = 8'h00;
  localparam logic [15:0] TCT_RST_COUNT = 16'h0000;

  // ==========================================================================
  // modes and prescaler
  localparam logic [1:0] TCT_M_13BIT = 2'h0;
  localparam logic [1:0] TCT_M_16BIT = 2'h1;
  localparam logic [1:0] TCT_M_RELOAD = 2'h2;
  localparam logic [1:0] TCT_M_SPLIT = 2'h3;
  localparam logic [1:0] TCT_PSC_D12 = 2'h0;
  localparam logic [1:0] TCT_PSC_D4 = 2'h1;
  localparam logic [1:0] TCT_PSC_D48 = 2'h2;
  localparam logic [1:0] TCT_PSC_EXT8 = 2'h3;
  localparam logic [5:0] TCT_DIV12 = 6'h0c;
  localparam logic [5:0] TCT_DIV4 = 6'h04;
  localparam logic [5:0] TCT_DIV48 = 6'h30;
  localparam logic [2:0] TCT_EXT_DIV_LAST = 3'h7;   // divide by 8

  // ==========================================================================
  // wishbone request carrier
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } tct_wb_req_s;

endpackage

// >>> tct_timer01.sv
/*
  Two counter/timers behind a classic Wishbone slave: four modes on the first, three on the second, which holds in mode 3.
  Assumes all pins arrive asynchronously and are synchronised here, and
  that the interrupt controller consumes the registered request outputs.
*/
`timescale 1ns/100ps

module tct_timer01
  import tct_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire tct_wb_req_s i_wb,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  input wire logic i_count0_pin,
  input wire logic i_count1_pin,
  input wire logic i_gating0,
  input wire logic i_gating1,
  input wire logic i_ext_clk,
  output logic o_irq0,
  output logic o_irq1,
  output logic o_ovf1_tick
);

  // ==========================================================================
  // synchronisers
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [4:0] prev_q;
  logic [4:0] fall;
  logic [4:0] rise;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= {i_ext_clk, i_gating1, i_gating0, i_count1_pin, i_count0_pin};
      sync2_q <= sync1_q;
    end
  end

  // edge reference; a low reset value cannot fake a falling edge
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prev_q <= 5'h00;
    end else begin
      prev_q <= sync2_q;
    end
  end

  // pulses no closer than every other cycle are caught; faster ones merge
  assign fall = prev_q & ~sync2_q;
  assign rise = ~prev_q & sync2_q;

  // ==========================================================================
  // registers
  logic [7:0] ctrl_q;
  logic [7:0] mode_q;
  logic [7:0] clk_q;
  logic [7:0] ext_q;
  logic [7:0] ien_q;
  logic [15:0] c0_q;
  logic [15:0] c1_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic acc;
  logic wr;

  assign acc = i_wb.cyc & i_wb.stb & ~ack_q;
  assign wr = acc & i_wb.we & i_wb.sel[0];

  // ==========================================================================
  // prescaler
  logic [5:0] div12_q;
  logic [5:0] div4_q;
  logic [5:0] div48_q;
  logic [2:0] ext_cnt_q;
  logic psc_tick;

  // dividers free-run, so a prescale change settles within one period
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div12_q <= 6'h00;
    end else begin
      div12_q <= (div12_q == TCT_DIV12 - 6'h01) ? 6'h00 : div12_q + 6'h01;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div4_q <= 6'h00;
    end else begin
      div4_q <= (div4_q == TCT_DIV4 - 6'h01) ? 6'h00 : div4_q + 6'h01;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div48_q <= 6'h00;
    end else begin
      div48_q <= (div48_q == TCT_DIV48 - 6'h01) ? 6'h00 : div48_q + 6'h01;
    end
  end

  // external clock edges counted on the synchronised copy only
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ext_cnt_q <= 3'h0;
    end else if (rise[4]) begin
      ext_cnt_q <= ext_cnt_q + 3'h1;
    end
  end

  always_comb begin
    case (clk_q[TCT_B_PSC +: 2])
      TCT_PSC_D12: psc_tick = (div12_q == TCT_DIV12 - 6'h01);
      TCT_PSC_D4: psc_tick = (div4_q == TCT_DIV4 - 6'h01);
      TCT_PSC_D48: psc_tick = (div48_q == TCT_DIV48 - 6'h01);
      TCT_PSC_EXT8: psc_tick = rise[4] & (ext_cnt_q == TCT_EXT_DIV_LAST);
      default: psc_tick = 1'b0;
    endcase
  end

  // ==========================================================================
  // count enables
  logic [1:0] m0;
  logic [1:0] m1;
  logic split;
  logic act0;
  logic act1;
  logic first_gating_input_tick;
  logic second_gating_input_tick;
  logic inc0;
  logic inc0h;
  logic inc1;

  assign m0 = mode_q[TCT_B_MODE0 +: 2];
  assign m1 = mode_q[TCT_B_MODE1 +: 2];
  assign split = (m0 == TCT_M_SPLIT);
  assign act0 = (sync2_q[2] == ext_q[TCT_B_POL0]);
  assign act1 = (sync2_q[3] == ext_q[TCT_B_POL1]);
  assign first_gating_input_tick = clk_q[TCT_B_CKS0] | psc_tick;
  assign second_gating_input_tick = clk_q[TCT_B_CKS1] | psc_tick;

  always_comb begin
    // first timer, also the low half in split mode
    inc0 = ctrl_q[TCT_B_RUN0] & (~mode_q[TCT_B_FIRST_GATE_BIT] | act0)
      & (mode_q[TCT_B_CSEL0] ? fall[0] : first_gating_input_tick);
    // split high half: internal clock, second run bit
    inc0h = split & ctrl_q[TCT_B_RUN1] & first_gating_input_tick;
    if (split) begin
      // run follows the mode alone, internal clock only
      inc1 = (m1 != TCT_M_SPLIT) & second_gating_input_tick;
    end else begin
      inc1 = ctrl_q[TCT_B_RUN1] & (~mode_q[TCT_B_GATE1] | act1)
        & (m1 != TCT_M_SPLIT)
        & (mode_q[TCT_B_CSEL1] ? fall[1] : second_gating_input_tick);
    end
  end

  // ==========================================================================
  // count step: returns {overflow, high, low}
  function automatic logic [16:0] tct_step(input logic [1:0] mode, input logic [15:0] cnt);
    logic [12:0] c13;
    logic [16:0] r;
    c13 = {cnt[15:8], cnt[4:0]} + 13'h0001;
    case (mode)
      TCT_M_13BIT: begin
        // upper low-byte bits are left untouched and carry no meaning
        r = {(c13 == 13'h0000), c13[12:5], cnt[7:5], c13[4:0]};
      end
      TCT_M_16BIT: begin
        r = {(cnt == 16'hffff), cnt + 16'h0001};
      end
      TCT_M_RELOAD: begin
        if (cnt[7:0] == 8'hff) begin
          r = {1'b1, cnt[15:8], cnt[15:8]};
        end else begin
          r = {1'b0, cnt[15:8], cnt[7:0] + 8'h01};
        end
      end
      default: begin
        r = {(cnt[7:0] == 8'hff), cnt[15:8], cnt[7:0] + 8'h01};
      end
    endcase
    return r;
  endfunction

  logic [16:0] s0;
  logic [16:0] s1;
  logic [8:0] s0h;
  logic set_ovf0;
  logic set_ovf1;
  logic ovf1_evt;

  assign s0 = tct_step(m0, c0_q);
  assign s1 = tct_step(m1, c1_q);
  assign s0h = {1'b0, c0_q[15:8]} + 9'h001;
  assign set_ovf0 = inc0 & s0[16];
  assign ovf1_evt = inc1 & s1[16];
  assign set_ovf1 = split ? (inc0h & s0h[8]) : ovf1_evt;

  // ==========================================================================
  // counts; a bus write to a byte wins over counting of that byte
  logic [15:0] c0_d;
  logic [15:0] c1_d;

  always_comb begin
    c0_d = c0_q;
    c1_d = c1_q;
    if (inc0) begin
      c0_d[7:0] = s0[7:0];
      if (!split) begin
        c0_d[15:8] = s0[15:8];
      end
    end
    if (inc0h) begin
      c0_d[15:8] = s0h[7:0];
    end
    if (inc1) begin
      c1_d = s1[15:0];
    end
    if (wr) begin
      case (i_wb.adr)
        TCT_OFS_C0L: c0_d[7:0] = i_wb.dat[7:0];
        TCT_OFS_C0H: c0_d[15:8] = i_wb.dat[7:0];
        TCT_OFS_C1L: c1_d[7:0] = i_wb.dat[7:0];
        TCT_OFS_C1H: c1_d[15:8] = i_wb.dat[7:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      c0_q <= TCT_RST_COUNT;
    end else begin
      c0_q <= c0_d;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      c1_q <= TCT_RST_COUNT;
    end else begin
      c1_q <= c1_d;
    end
  end

  // ==========================================================================
  // configuration registers; run bits never touch the count
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_q <= TCT_RST_BYTE;
      clk_q <= TCT_RST_BYTE;
      ext_q <= TCT_RST_BYTE;
      ien_q <= TCT_RST_BYTE;
    end else if (wr) begin
      case (i_wb.adr)
        TCT_OFS_MODE: mode_q <= i_wb.dat[7:0];
        TCT_OFS_CLK: clk_q <= i_wb.dat[7:0];
        TCT_OFS_EXT: ext_q <= i_wb.dat[7:0];
        TCT_OFS_IEN: ien_q <= i_wb.dat[7:0];
        default: begin
        end
      endcase
    end
  end

  // control/status: a hardware overflow beats a same-cycle software clear
  logic [7:0] ctrl_d;

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr && i_wb.adr == TCT_OFS_CTRL) begin
      ctrl_d = i_wb.dat[7:0];
    end
    if (set_ovf0) begin
      ctrl_d[TCT_B_OVF0] = 1'b1;
    end
    if (set_ovf1) begin
      ctrl_d[TCT_B_OVF1] = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_q <= TCT_RST_BYTE;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ==========================================================================
  // outputs
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq0 <= 1'b0;
      o_irq1 <= 1'b0;
    end else begin
      o_irq0 <= ctrl_q[TCT_B_OVF0] & ien_q[TCT_B_IEN0];
      o_irq1 <= ctrl_q[TCT_B_OVF1] & ien_q[TCT_B_IEN1];
    end
  end

  // tick ignores the flag path, so split mode still feeds it
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ovf1_tick <= 1'b0;
    end else begin
      o_ovf1_tick <= ovf1_evt;
    end
  end

  // ==========================================================================
  // wishbone slave: one wait state, unmapped reads return zero
  logic [7:0] rbyte;

  always_comb begin
    case (i_wb.adr)
      TCT_OFS_CTRL: rbyte = ctrl_q;
      TCT_OFS_MODE: rbyte = mode_q;
      TCT_OFS_CLK: rbyte = clk_q;
      TCT_OFS_EXT: rbyte = ext_q;
      TCT_OFS_C0L: rbyte = c0_q[7:0];
      TCT_OFS_C0H: rbyte = c0_q[15:8];
      TCT_OFS_C1L: rbyte = c1_q[7:0];
      TCT_OFS_C1H: rbyte = c1_q[15:8];
      TCT_OFS_IEN: rbyte = ien_q;
      default: rbyte = 8'h00;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= acc;
      if (acc) begin
        rdat_q <= {24'h00_0000, rbyte};
      end
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;

endmodule

// >>> tct_timer01_monitor.sv
/*
  Checker for the timer block's bus and interrupt outputs.
  Assumes it is bound to tct_timer01 and sees only its ports.
*/
`timescale 1ns/100ps
module tct_timer01_monitor
  import tct_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire tct_wb_req_s i_wb,
  input wire logic o_wb_ack,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_irq0,
  input wire logic o_irq1,
  input wire logic o_ovf1_tick
);
  default clocking mon_cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);
  // ==========================================================================
  // bus handshake
  a_ack_after_req: assert property (i_wb.cyc && i_wb.stb && !o_wb_ack |=> o_wb_ack)
    else $error("no ack one cycle after a request");
  a_ack_one_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  a_ack_has_cause: assert property ($rose(o_wb_ack) |-> $past(i_wb.cyc && i_wb.stb))
    else $error("ack without a request");
  a_dat_upper_zero: assert property (o_wb_dat[31:8] == 24'h0)
    else $error("read data above the byte lane not zero");
  a_dat_holds: assert property (!$stable(o_wb_dat) |-> $rose(o_wb_ack))
    else $error("read data changed outside an answer");
  // ==========================================================================
  // interrupts: a flag only drops by a software write, two edges before
  a_irq0_clear: assert property ($fell(o_irq0) |-> $past(i_wb.cyc && i_wb.stb && i_wb.we, 2))
    else $error("first interrupt dropped without a write");
  a_irq1_clear: assert property ($fell(o_irq1) |-> $past(i_wb.cyc && i_wb.stb && i_wb.we, 2))
    else $error("second interrupt dropped without a write");
  a_reset_quiet: assert property (disable iff (1'b0) $rose(i_reset_n) |->
    !(o_wb_ack || o_irq0 || o_irq1 || o_ovf1_tick) && o_wb_dat == 32'h0)
    else $error("outputs not idle after reset");
endmodule

bind tct_timer01 tct_timer01_monitor u_mon (.i_mclk, .i_reset_n, .i_wb, .o_wb_ack,
  .o_wb_dat, .o_irq0, .o_irq1, .o_ovf1_tick);

// >>> tct_wb_host.sv
/*
  Classic Wishbone master standing in for the processor core.
  Assumes one clock and a slave that answers with a registered ack.
*/
`timescale 1ns/100ps
module tct_wb_host
  import tct_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_ack,
  input wire logic [31:0] i_dat,
  output tct_wb_req_s o_wb
);
  // ==========================================================================
  // bus cycle
  initial o_wb = '0;
  // the idle edge at the end keeps cyc low between back-to-back calls
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge i_mclk);
    o_wb <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, d}};
    do @(posedge i_mclk); while (i_ack !== 1'b1);
    q = i_dat[7:0];
    o_wb <= '0;
    @(posedge i_mclk);
  endtask
endmodule
